// file: tape_punch_pkg.sv
// Package for the paper tape punch output port.
// Assumes a 20 MHz system clock; timing counts are derived from it.
package tape_punch_pkg;

    // System clock rate in kHz (20 MHz, 50 ns period)
    localparam int unsigned CLK_KHZ       = 20000;

    // Punch cycle length and its phases, in microseconds as printed
    localparam int unsigned CYCLE_US      = 16700;
    localparam int unsigned REFERENCE_US  = 12500;
    localparam int unsigned READY_US      = 4200;

    // Cycle counts; all figures are exact at 20 MHz, rounding kept for safety
    localparam int unsigned CYCLE_CLKS     = (CYCLE_US * CLK_KHZ) / 1000;
    localparam int unsigned REFERENCE_CLKS = (REFERENCE_US * CLK_KHZ + 999) / 1000;
    localparam int unsigned READY_CLKS     = (READY_US * CLK_KHZ) / 1000;

    // Width of the phase counter inside one punch cycle
    localparam int unsigned PHASE_W       = 19;

    // Buffer geometry
    localparam int unsigned OPERAND_W     = 6;
    localparam int unsigned FRAME_W       = 7;
    localparam int unsigned J_STAGE       = 6;

    // Frame FIFO towards the punch mechanism
    localparam int unsigned FIFO_DEPTH    = 8;

    // Reset value of the frame buffer
    localparam logic [6:0]  BUFFER_RESET  = 7'h00;

    // Auxiliary field value that sets the seventh stage
    localparam logic        J_SETS_TOP    = 1'h1;

    // One punch frame instruction as delivered by the processor
    typedef struct packed {
        logic       j_field;   // Auxiliary field, one sets the seventh stage
        logic [5:0] operand;   // Low six bits of the operand via transfer register
    } punch_instr_t;

    // One tape frame, index k holds tape level k+1
    typedef struct packed {
        logic [6:0] level;
    } tape_frame_t;

    // State of the frame buffer
    typedef enum logic [1:0] {
        BUF_EMPTY     = 2'b00,  // Cleared, ready for a frame
        BUF_LOADED    = 2'b01,  // Holding a frame, waiting for next cycle
        BUF_REFERENCE = 2'b10   // Punch reference in progress
    } buf_state_t;

endpackage

// file: frame_fifo.sv
// Small synchronous FIFO holding punched frames on their way to the mechanism.
// Assumes one clock and an asynchronous active-low reset; width and depth are parameters.
`timescale 1ns/1ns
module frame_fifo #(
    parameter int unsigned WIDTH = 7,
    parameter int unsigned DEPTH = 8
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             resetn_i,
    // Write side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // Read side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];      // Storage words, all flip-flops
    logic [AW-1:0]    wr_ptr;           // Next slot to write
    logic [AW-1:0]    rd_ptr;           // Oldest slot
    logic [AW:0]      count;            // Words held
    wire              push;             // Accepted write
    wire              pop;              // Accepted read

    // Honest flags straight from the fill count
    // Room is left while fewer than DEPTH words are held; an empty FIFO must accept
    assign in_ready_o  = (count < (AW+1)'(DEPTH));
    assign out_valid_o = (count != '0);
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;
    // Read data come from a storage register, never from logic
    assign out_data_o  = mem[rd_ptr];

    // Storage write; no reset needed on data, only on pointers and count
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    // Pointers and count; wrap relies on DEPTH being a power of two
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            wr_ptr <= push ? wr_ptr + 1'b1 : wr_ptr;
            rd_ptr <= pop ? rd_ptr + 1'b1 : rd_ptr;
            count  <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

endmodule

// file: tape_punch_port.sv
// Paper tape punch output port: frame buffer, punch cycle timing, lockout, frame FIFO.
// Assumes the processor holds its instruction while stalled and the mechanism
// takes frames with a valid/ready handshake; one 20 MHz clock.
`timescale 1ns/1ns
module tape_punch_port
    import tape_punch_pkg::*;
#(
    // Punch cycle counts; shorten these for simulation
    parameter int unsigned CYCLE_LEN     = tape_punch_pkg::CYCLE_CLKS,
    parameter int unsigned REFERENCE_LEN = tape_punch_pkg::REFERENCE_CLKS
) (
    // Clock and reset
    input  wire logic                       clk_i,
    input  wire logic                       resetn_i,
    // Processor instruction side
    input  wire logic                       instr_valid_i,
    input  wire tape_punch_pkg::punch_instr_t instr_i,
    output logic                            instr_ready_o,
    output logic                            lockout_o,
    // Enable switches
    input  wire logic                       punch_switch_i,
    input  wire logic                       panel_switch_i,
    // Punch mechanism side
    output logic                            punch_valid_o,
    input  wire logic                       punch_ready_i,
    output tape_punch_pkg::tape_frame_t     punch_frame_o,
    output logic                            tape_advance_o,
    // Status
    output logic                            cycle_start_o,
    output logic [1:0]                      buffer_state_o
);
    import tape_punch_pkg::*;

    // Phase counter width check is the designer's job; the package width
    // covers the full 16.7 ms cycle with margin.
    localparam logic [PHASE_W-1:0] LAST_PHASE = PHASE_W'(CYCLE_LEN - 1);
    localparam logic [PHASE_W-1:0] REF_DONE   = PHASE_W'(REFERENCE_LEN - 1);

    // Map buffer stages onto tape levels. Stage 6 is level 7, stage 5 is
    // level 6, stages 4..0 are levels 1..5. Used for the FIFO word and
    // kept as a function so the wiring is written once.
    function automatic logic [6:0] to_levels(input logic [6:0] stages);
        logic [6:0] lv;
        lv    = '0;
        lv[6] = stages[6];   // Level 7
        lv[5] = stages[5];   // Level 6
        lv[0] = stages[4];   // Level 1
        lv[1] = stages[3];   // Level 2
        lv[2] = stages[2];   // Level 3
        lv[3] = stages[1];   // Level 4
        lv[4] = stages[0];   // Level 5
        return lv;
    endfunction

    // Registers
    logic [PHASE_W-1:0] phase;               // Position within the punch cycle
    logic [6:0]         punch_frame_buffer;  // The seven-stage frame buffer
    buf_state_t         state;               // Buffer state
    logic               advance;             // Tape advance pulse register
    logic               cycle_pulse;         // Cycle start pulse register

    // Next values
    logic [PHASE_W-1:0] next_phase;
    logic [6:0]         next_buffer;
    buf_state_t         next_state;

    // Decoded conditions
    wire                enabled;             // Both switches on
    wire                cycle_end;           // Last clock of the current cycle
    wire                ref_end;             // Last clock of the reference window
    wire                load;                // Instruction accepted this clock
    wire [6:0]          load_bits;           // Stages to set on load
    wire                fifo_in_ready;       // FIFO can take the finished frame
    wire                fifo_push;           // Finished frame written this clock
    wire                fifo_out_valid;      // FIFO holds a frame for the punch
    wire [6:0]          fifo_out_data;       // Oldest frame in tape level order
    wire                punch_take;          // Mechanism took a frame

    // Either switch off stops the cycle clock and all punching
    assign enabled = punch_switch_i & panel_switch_i;

    // Cycle boundaries from the free-running phase counter
    assign cycle_end = enabled & (phase == LAST_PHASE);
    assign ref_end   = enabled & (phase == REF_DONE);

    // The buffer takes a new frame only when it is empty. Emptying happens
    // at the end of the 12.5 ms reference, so readiness shows only in the
    // last 4.2 ms of that cycle, and any earlier instruction waits.
    assign instr_ready_o = enabled & (state == BUF_EMPTY);
    // A held instruction that cannot be taken stalls the processor
    assign lockout_o     = instr_valid_i & ~instr_ready_o;
    assign load          = instr_valid_i & instr_ready_o;

    // Operand low six bits come via the transfer register; the auxiliary
    // field sets the seventh stage on its own path
    assign load_bits[5:0] = instr_i.operand;
    assign load_bits[6]   = (instr_i.j_field == J_SETS_TOP);

    // The reference completes only when the FIFO can take the frame; a full
    // FIFO holds the reference, which in turn keeps the processor stalled.
    assign fifo_push = (state == BUF_REFERENCE) & ref_end & fifo_in_ready;

    // Mechanism takes frames only while enabled
    assign punch_valid_o = fifo_out_valid & enabled;
    assign punch_take    = punch_valid_o & punch_ready_i;
    // Frame levels straight from the FIFO storage register
    assign punch_frame_o.level = fifo_out_data;

    // Status outputs
    assign tape_advance_o = advance;
    assign cycle_start_o  = cycle_pulse;
    assign buffer_state_o = state;

    // Phase counter advance; frozen while disabled
    always_comb begin
        next_phase = phase;
        if (enabled) begin
            // Wrap at the end of each fixed cycle
            if (cycle_end) begin
                next_phase = '0;
            end else begin
                next_phase = phase + 1'b1;
            end
        end
    end

    // Buffer state machine
    always_comb begin
        next_state  = state;
        next_buffer = punch_frame_buffer;
        case (state)
            BUF_EMPTY: begin
                // Set-only load: zeros leave stages as they are
                if (load) begin
                    next_buffer = punch_frame_buffer | load_bits;
                    next_state  = BUF_LOADED;
                end
            end
            BUF_LOADED: begin
                // Reference starts only when the next cycle begins
                if (cycle_end) begin
                    next_state = BUF_REFERENCE;
                end
            end
            BUF_REFERENCE: begin
                // Reference occupies the first 12.5 ms of the cycle
                if (fifo_push) begin
                    next_buffer = BUFFER_RESET;
                    next_state  = BUF_EMPTY;
                end
            end
            default: begin
                // Unused code falls back to a clean empty buffer
                next_buffer = BUFFER_RESET;
                next_state  = BUF_EMPTY;
            end
        endcase
    end

    // Phase and buffer registers
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            phase              <= '0;
            punch_frame_buffer <= BUFFER_RESET;
            state              <= BUF_EMPTY;
        end else begin
            phase              <= next_phase;
            punch_frame_buffer <= next_buffer;
            state              <= next_state;
        end
    end

    // Pulses: tape advance after each take, cycle start after each wrap
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            advance     <= 1'b0;
            cycle_pulse <= 1'b0;
        end else begin
            advance     <= punch_take;
            cycle_pulse <= cycle_end;
        end
    end

    // The program's job of shifting a 36-bit word into six-bit groups and
    // issuing six punches is outside this port; each instruction is one
    // frame here, whatever the program intends.

    // Frame FIFO between finished references and the mechanism. It lets the
    // mechanism lag a few frames without losing the cycle rhythm.
    frame_fifo #(
        .WIDTH (FRAME_W),
        .DEPTH (FIFO_DEPTH)
    ) u_frame_fifo (
        .clk_i       (clk_i),
        .resetn_i    (resetn_i),
        .in_valid_i  (fifo_push),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (to_levels(punch_frame_buffer)),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (punch_take),
        .out_data_o  (fifo_out_data)
    );

endmodule

// file: tape_mech_model.sv
// Behavioural model of the punch mechanism that takes frames from the port.
// Assumes one clock; the bench steers its pace through stall and slow controls.
`timescale 1ns/1ns
module tape_mech_model (
    // Clock and reset
    input  wire logic                        clk_i,
    input  wire logic                        resetn_i,
    // Port side
    input  wire logic                        punch_valid_i,
    input  wire tape_punch_pkg::tape_frame_t punch_frame_i,
    input  wire logic                        tape_advance_i,
    output logic                             punch_ready_o,
    // Bench controls
    input  wire logic                        stall_i,
    input  wire logic                        slow_i
);
    import tape_punch_pkg::*;
    tape_frame_t got[$];     // Frames punched, oldest first
    int          advances;   // Tape positions moved
    logic        toggle;     // Halves the take rate in slow mode

    // Slow mode takes on every other cycle only, to stall the FIFO now and then
    assign punch_ready_o = !stall_i && (!slow_i || toggle);

    // Record each frame taken and each tape step
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            toggle <= 1'b0;
            advances <= 0;
        end else begin
            toggle <= ~toggle;
            if (tape_advance_i) advances <= advances + 1;
            if (punch_valid_i && punch_ready_o) got.push_back(punch_frame_i);
        end
    end
endmodule

// file: tape_punch_port_assertions.sv
// Checker for the tape punch port, watching its ports only.
// Assumes the single clock domain; bound into every instance of the port.
`timescale 1ns/1ns
module tape_punch_port_checker #(
    parameter int unsigned CYCLE_LEN     = 20,
    parameter int unsigned REFERENCE_LEN = 15
) (
    // Clock and reset
    input  wire logic                         clk_i,
    input  wire logic                         resetn_i,
    // Processor side
    input  wire logic                         instr_valid_i,
    input  wire tape_punch_pkg::punch_instr_t instr_i,
    input  wire logic                         instr_ready_o,
    input  wire logic                         lockout_o,
    // Switches
    input  wire logic                         punch_switch_i,
    input  wire logic                         panel_switch_i,
    // Mechanism side
    input  wire logic                         punch_valid_o,
    input  wire logic                         punch_ready_i,
    input  wire tape_punch_pkg::tape_frame_t  punch_frame_o,
    input  wire logic                         tape_advance_o,
    // Status
    input  wire logic                         cycle_start_o,
    input  wire logic [1:0]                   buffer_state_o
);
    import tape_punch_pkg::*;
    logic        both_on;  // Both enable switches on
    logic [31:0] gap;      // Clocks since the last cycle pulse
    logic        armed;    // A full enabled cycle is being timed
    logic [31:0] ref_cnt;  // Clocks spent in the reference state

    assign both_on = punch_switch_i && panel_switch_i;

    // Gap timing is dropped whenever a switch is off, since the phase freezes
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            gap <= 32'h0;
            armed <= 1'b0;
            ref_cnt <= 32'h0;
        end else begin
            gap <= cycle_start_o ? 32'h1 : gap + 32'h1;
            armed <= both_on && (armed || cycle_start_o);
            ref_cnt <= (buffer_state_o == 2'h2) ? ref_cnt + 32'h1 : 32'h0;
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);

    sequence s_take;
        instr_valid_i && instr_ready_o;
    endsequence
    sequence s_held;
        punch_valid_o && !punch_ready_i && both_on ##1 both_on;
    endsequence

    ready_gate_a: assert property (instr_ready_o == (both_on && buffer_state_o == 2'h0))
        else $error("ready does not follow switches and empty buffer");
    lockout_def_a: assert property (lockout_o == (instr_valid_i && !instr_ready_o))
        else $error("lockout does not match refused request");
    load_state_a: assert property (s_take |=> buffer_state_o == 2'h1)
        else $error("taken frame not held as loaded");
    loaded_hold_a: assert property (buffer_state_o == 2'h1 |=> buffer_state_o inside {2'h1, 2'h2})
        else $error("loaded frame skipped its reference");
    advance_step_a: assert property (tape_advance_o == $past(punch_valid_o && punch_ready_i))
        else $error("tape advance not one clock after take");
    frame_hold_a: assert property (s_held |-> punch_valid_o && $stable(punch_frame_o))
        else $error("offered frame changed before take");
    switch_gate_a: assert property (!both_on |-> !punch_valid_o && !instr_ready_o)
        else $error("activity with a switch off");
    cycle_period_a: assert property (armed |-> gap <= CYCLE_LEN && (!cycle_start_o || gap == CYCLE_LEN))
        else $error("punch cycle length wrong");
    ref_length_a: assert property ($fell(buffer_state_o == 2'h2) |-> ref_cnt >= REFERENCE_LEN)
        else $error("reference ended early");
endmodule

bind tape_punch_port tape_punch_port_checker #(
    .CYCLE_LEN     (CYCLE_LEN),
    .REFERENCE_LEN (REFERENCE_LEN)
) i_checker (.clk_i, .resetn_i, .instr_valid_i, .instr_i, .instr_ready_o, .lockout_o,
    .punch_switch_i, .panel_switch_i, .punch_valid_o, .punch_ready_i, .punch_frame_o,
    .tape_advance_o, .cycle_start_o, .buffer_state_o);

// file: paper_tape_punch_output_bench.sv
// Self-checking bench for the tape punch port with a mechanism model.
// Assumes a shortened punch cycle of 20 clocks and reference of 15 clocks at 20 MHz.
`timescale 1ns/1ns
module paper_tape_punch_output_bench;
    import tape_punch_pkg::*;
    localparam int CL = 20;  // Shortened punch cycle
    localparam int RL = 15;  // Shortened reference
    logic         clk_i = 1'b0;
    logic         resetn_i = 1'b0;
    logic         instr_valid_i = 1'b0;
    punch_instr_t instr_i = '0;
    logic         punch_switch_i = 1'b1;
    logic         panel_switch_i = 1'b1;
    logic         stall = 1'b0;
    logic         slow = 1'b0;
    logic         instr_ready_o, lockout_o, punch_valid_o, punch_ready_i;
    logic         tape_advance_o, cycle_start_o;
    logic [1:0]   buffer_state_o;
    tape_frame_t  punch_frame_o;
    tape_frame_t  exp_q[$];  // Frames expected at the mechanism
    int           miscompares = 0;
    int           tests_run = 0;
    int           ticks = 0;
    int           total = 0;  // Frames expected since reset

    tape_punch_port #(.CYCLE_LEN(CL), .REFERENCE_LEN(RL)) i_dut (.clk_i, .resetn_i,
        .instr_valid_i, .instr_i, .instr_ready_o, .lockout_o, .punch_switch_i,
        .panel_switch_i, .punch_valid_o, .punch_ready_i, .punch_frame_o,
        .tape_advance_o, .cycle_start_o, .buffer_state_o);
    tape_mech_model i_mech (.clk_i, .resetn_i, .punch_valid_i(punch_valid_o),
        .punch_frame_i(punch_frame_o), .tape_advance_i(tape_advance_o),
        .punch_ready_o(punch_ready_i), .stall_i(stall), .slow_i(slow));

    initial forever #25 clk_i = ~clk_i;

    // Hang guard, well above the expected run of about 660 clocks
    always @(posedge clk_i) begin
        ticks++;
        if (ticks == 4000) begin
            miscompares++;
            conclude();
        end
    end

    task automatic check_num(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_frame(input tape_frame_t got, input tape_frame_t exp);
        check_num({25'h0, got}, {25'h0, exp});
    endtask

    // Stage six is the auxiliary bit; levels are stored as level k+1 at index k
    function automatic tape_frame_t map_frame(input logic j, input logic [5:0] op);
        map_frame.level = {j, op[5], op[0], op[1], op[2], op[3], op[4]};
    endfunction

    // Holds the request until taken; returns clocks waited and lockout clocks
    // Ready and lockout are read mid-cycle, where they are settled for the coming edge
    task automatic issue(input logic j, input logic [5:0] op, output int wt, output int lk);
        logic taken;
        wt = 0;
        lk = 0;
        taken = 1'b0;
        instr_valid_i <= 1'b1;
        instr_i <= '{j, op};
        exp_q.push_back(map_frame(j, op));
        do begin
            @(negedge clk_i);
            taken = (instr_ready_o === 1'b1);
            if (lockout_o === 1'b1) lk++;
            @(posedge clk_i);
            wt++;
        end while (!taken && wt < 2000);
    endtask

    task automatic drain(input string name);
        int n;
        n = 0;
        while (i_mech.got.size() < exp_q.size() && n < 1000) begin
            @(posedge clk_i);
            n++;
        end
        repeat (2) @(posedge clk_i);
        @(negedge clk_i);
        total += exp_q.size();
        check_num(i_mech.got.size(), exp_q.size());
        foreach (exp_q[k]) check_frame(i_mech.got[k], exp_q[k]);
        check_num(i_mech.advances, total);
        check_num(punch_valid_o, 1'b0);
        exp_q = {};
        i_mech.got = {};
        $display("Test %s finished", name);
        @(posedge clk_i);
    endtask

    // A whole word in six back-to-back punches, so each from the third on waits a full cycle
    task automatic test_word;
        logic [35:0] w;
        int          wt;
        int          lk;
        w = 36'hFC006A560;
        slow <= 1'b1;
        for (int k = 0; k < 6; k++) begin
            w = {w[29:0], w[35:30]};
            issue(k[0], w[5:0], wt, lk);
            if (k > 1) check_num(wt, CL);
            if (k > 1) check_num(lk, CL - 1);
        end
        instr_valid_i <= 1'b0;
        drain("word");
    endtask

    // Each switch alone must stop both the mechanism and the processor side
    task automatic test_switch;
        int wt;
        int lk;
        for (int s = 0; s < 2; s++) begin
            stall <= 1'b1;
            issue(1'b0, 6'h15 + s[5:0], wt, lk);
            instr_valid_i <= 1'b0;
            repeat (2 * CL) @(posedge clk_i);
            check_num(punch_valid_o, 1'b1);
            if (s == 0) panel_switch_i <= 1'b0;
            else punch_switch_i <= 1'b0;
            instr_valid_i <= 1'b1;
            instr_i <= '{1'b1, 6'h2A};
            repeat (2 * CL) @(posedge clk_i);
            check_num({lockout_o, instr_ready_o, punch_valid_o}, 3'h4);
            panel_switch_i <= 1'b1;
            punch_switch_i <= 1'b1;
            stall <= 1'b0;
            issue(1'b1, 6'h2A, wt, lk);
            instr_valid_i <= 1'b0;
            drain("switch");
        end
    endtask

    // Fill the FIFO with the mechanism stalled, then a tenth frame is locked out
    task automatic test_fifo;
        int wt;
        int lk;
        stall <= 1'b1;
        slow <= 1'b0;
        for (int k = 0; k < 9; k++) issue(k[0], k[5:0], wt, lk);
        instr_i <= '{1'b1, 6'h3F};
        repeat (3 * CL) @(posedge clk_i);
        check_num({lockout_o, buffer_state_o}, 3'h6);
        stall <= 1'b0;
        issue(1'b1, 6'h3F, wt, lk);
        instr_valid_i <= 1'b0;
        drain("fifo");
    endtask

    task automatic conclude;
        $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge clk_i);
        resetn_i <= 1'b1;
        @(posedge clk_i);
        test_word();
        test_switch();
        test_fifo();
        conclude();
    end
endmodule
